// >>> core/ras_defines.svh
// constants for the return address stack
`ifndef RAS_DEFINES_SVH
`define RAS_DEFINES_SVH

`define RAS_DEPTH 16
`define RAS_IDX_W 4
`define RAS_CNT_W 5
`define RAS_PC_W 15
`define RAS_FULL_CNT 5'h10
`define RAS_EMPTY_CNT 5'h00
`define RAS_IDX_ONE 4'h1
`define RAS_CNT_ONE 5'h01
`define RAS_RST_IDX 4'h0
`define RAS_RST_CNT 5'h00
`define RAS_RST_FLAG 1'b0
`define RAS_STAT_OFF 32'h0000_0000
`define RAS_FLAG_BIT 7
`define RAS_PAD_W 3
`define RAS_PAD_VAL 3'h0
`define RAS_HI_PAD 24'h00_0000
`define RAS_ZERO_WORD 32'h0000_0000
`define RAS_HRESP_OKAY 1'b0

`endif

// >>> core/ras_pkg.sv
// types shared by the return address stack
`include "ras_defines.svh"

package ras_pkg;

  typedef logic [`RAS_PC_W-1:0] ras_pc_t;

  typedef struct packed {
    logic call;
    logic return_from_subroutine;
    logic return_from_interrupt;
    ras_pc_t pc;
  } ras_core_req_t;

  typedef struct packed {
    logic stack_overflow_flag;
    logic [`RAS_PAD_W-1:0] pad;
    logic [`RAS_IDX_W-1:0] level_index_bits;
  } ras_status_t;

endpackage : ras_pkg

// >>> core/ras_top.sv
// return address stack with its status register on an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "ras_defines.svh"

module ras_top
  import ras_pkg::*;
#(
  parameter int DEPTH = `RAS_DEPTH
)
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output var logic [31:0] HRDATA,
  output var logic HREADYOUT,
  output var logic HRESP,
  input wire ras_core_req_t CORE_REQ,
  input wire logic IRQ_REQ,
  output var logic IRQ_ACK,
  output var ras_pc_t PC_OUT,
  output var logic PC_OUT_VALID
);

  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  generate
    if (DEPTH != (1 << `RAS_IDX_W))
    begin : g_bad_depth
      $error("depth must match the four-bit level index");
    end
  endgenerate

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  // hidden store
  ras_pc_t mem [DEPTH];
  logic [`RAS_IDX_W-1:0] stack_level_index;
  logic [`RAS_CNT_W-1:0] occupancy;
  logic stack_overflow_flag;
  logic wr_pend;
  logic [31:0] wr_addr;

  logic full;
  logic empty;
  logic any_return;
  logic irq_take;
  logic push;
  logic pop;
  logic set_flag;
  logic wr_hit;
  logic ahb_go;
  logic [`RAS_IDX_W-1:0] next_index;
  logic [`RAS_IDX_W-1:0] top_index;
  ras_status_t status;

  // --------------------------------------------------------------
  // stack events
  // --------------------------------------------------------------
  // occupancy decides full and empty
  assign full = (occupancy == `RAS_FULL_CNT);
  assign empty = (occupancy == `RAS_EMPTY_CNT);
  assign any_return = CORE_REQ.return_from_subroutine | CORE_REQ.return_from_interrupt;

  // no acknowledge while full
  // ack is skipped in a cycle with a call or return so one push per cycle
  assign irq_take = IRQ_REQ & ~IRQ_ACK & ~full & ~CORE_REQ.call & ~any_return;

  // a call in the same cycle as a return wins; the core never issues both
  assign push = CORE_REQ.call | irq_take;
  assign pop = any_return & ~CORE_REQ.call;

  assign set_flag = (CORE_REQ.call & full) | (pop & empty);

  assign top_index = stack_level_index - `RAS_IDX_ONE;

  always_comb
  begin
    next_index = stack_level_index;
    if (push)
    begin
      next_index = stack_level_index + `RAS_IDX_ONE;
    end
    else if (pop)
    begin
      next_index = top_index;
    end
  end

  // --------------------------------------------------------------
  // entry store
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_entry
      // full push overwrites oldest
      // the index already points at the oldest entry when full
      always_ff @(posedge CLK)
      begin
        if (push && (stack_level_index == `RAS_IDX_W'(g)))
        begin
          mem[g] <= CORE_REQ.pc;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // level index and occupancy
  // --------------------------------------------------------------
  // index selects active entry
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      stack_level_index <= `RAS_RST_IDX;
    end
    else
    begin
      stack_level_index <= next_index;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      occupancy <= `RAS_RST_CNT;
    end
    else if (push && !full)
    begin
      occupancy <= occupancy + `RAS_CNT_ONE;
    end
    else if (pop && !empty)
    begin
      occupancy <= occupancy - `RAS_CNT_ONE;
    end
  end

  // --------------------------------------------------------------
  // core outputs
  // --------------------------------------------------------------
  // restore from last saved entry
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      PC_OUT <= '0;
      PC_OUT_VALID <= 1'b0;
    end
    else
    begin
      PC_OUT_VALID <= pop;
      if (pop)
      begin
        PC_OUT <= mem[top_index];
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      IRQ_ACK <= 1'b0;
    end
    else
    begin
      IRQ_ACK <= irq_take;
    end
  end

  // --------------------------------------------------------------
  // overflow flag
  // --------------------------------------------------------------
  // sticky; hardware set beats software write
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      stack_overflow_flag <= `RAS_RST_FLAG;
    end
    else if (set_flag)
    begin
      stack_overflow_flag <= 1'b1;
    end
    else if (wr_hit)
    begin
      stack_overflow_flag <= HWDATA[`RAS_FLAG_BIT];
    end
  end

  // --------------------------------------------------------------
  // ahb-lite slave
  // --------------------------------------------------------------
  // zero wait states; size is not checked, every access is a word
  assign ahb_go = HSEL & HTRANS[1] & HREADY;
  assign wr_hit = wr_pend & (wr_addr == `RAS_STAT_OFF);

  always_comb
  begin
    status.stack_overflow_flag = stack_overflow_flag;
    status.pad = `RAS_PAD_VAL;
    status.level_index_bits = stack_level_index;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      wr_pend <= 1'b0;
      wr_addr <= `RAS_ZERO_WORD;
    end
    else
    begin
      wr_pend <= ahb_go & HWRITE;
      wr_addr <= HADDR;
    end
  end

  // read data sampled in the address phase; unmapped reads give zero
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      HRDATA <= `RAS_ZERO_WORD;
    end
    else if (ahb_go && !HWRITE && (HADDR == `RAS_STAT_OFF))
    begin
      HRDATA <= {`RAS_HI_PAD, status};
    end
    else
    begin
      HRDATA <= `RAS_ZERO_WORD;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      HREADYOUT <= 1'b1;
      HRESP <= `RAS_HRESP_OKAY;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP <= `RAS_HRESP_OKAY;
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking

  sequence s_push;
    push;
  endsequence

  sequence s_pop_empty;
    pop && empty;
  endsequence

  sequence s_call_full;
    CORE_REQ.call && full;
  endsequence

  push_store_a: assert property (disable iff (!RESETN)
    s_push |=> (mem[$past(stack_level_index)] == $past(CORE_REQ.pc))
      && (stack_level_index == $past(stack_level_index) + `RAS_IDX_ONE))
    else $error("push did not store pc or advance index");

  pop_restore_a: assert property (disable iff (!RESETN)
    pop |=> PC_OUT_VALID && (PC_OUT == $past(mem[top_index]))
      && (stack_level_index == $past(top_index)))
    else $error("return did not restore pc");

  reset_values_a: assert property (disable iff (1'b0)
    !RESETN |=> (stack_level_index == `RAS_RST_IDX) && !stack_overflow_flag
      && (occupancy == `RAS_RST_CNT))
    else $error("reset state wrong");

  ack_holdoff_a: assert property (disable iff (!RESETN)
    full |=> !IRQ_ACK)
    else $error("interrupt acknowledged on full stack");

  full_call_a: assert property (disable iff (!RESETN)
    s_call_full |=> full && (stack_level_index == $past(stack_level_index) + `RAS_IDX_ONE))
    else $error("full call did not proceed");

  // flag set by overflow or underflow
  flag_set_a: assert property (disable iff (!RESETN)
    (s_call_full or s_pop_empty) |=> stack_overflow_flag)
    else $error("overflow flag not set");

  flag_sticky_a: assert property (disable iff (!RESETN)
    stack_overflow_flag && !wr_hit |=> stack_overflow_flag)
    else $error("overflow flag cleared by hardware");

  // sixteenth push from fifteen wraps to zero
  index_wrap_a: assert property (disable iff (!RESETN)
    push && !wr_hit && (stack_level_index == 4'hF) && !full |=> (stack_level_index == 4'h0)
      && (stack_overflow_flag == $past(stack_overflow_flag)))
    else $error("index did not wrap on push");

  under_wrap_a: assert property (disable iff (!RESETN)
    s_pop_empty |=> (stack_level_index == $past(stack_level_index) - `RAS_IDX_ONE)
      && empty && stack_overflow_flag)
    else $error("empty return wrong");

  read_layout_a: assert property (disable iff (!RESETN)
    ahb_go && !HWRITE && (HADDR == `RAS_STAT_OFF) |=>
      (HRDATA[6:4] == `RAS_PAD_VAL) && (HRDATA[3:0] == $past(stack_level_index))
      && (HRDATA[7] == $past(stack_overflow_flag)))
    else $error("status read layout wrong");

  occ_bound_a: assert property (disable iff (!RESETN)
    occupancy <= `RAS_FULL_CNT)
    else $error("occupancy out of range");

  wr_index_a: assert property (disable iff (!RESETN)
    wr_hit && !push && !pop |=> stack_level_index == $past(stack_level_index))
    else $error("software write changed index");

endmodule : ras_top

`default_nettype wire

// >>> sim/ras_core_model.sv
// core sequencer model: calls, returns and interrupt requests
`timescale 1ns/1ps
`default_nettype none

module ras_core_model
  import ras_pkg::*;
(
  input wire logic clk,
  input wire logic irq_ack,
  output var ras_core_req_t core_req,
  output var logic irq_req
);
  int asked = 0;
  int acks = 0;

  initial core_req = '0;
  initial irq_req = 1'b0;

  always @(posedge clk)
  begin
    acks <= acks + int'(irq_ack);
    irq_req <= (asked != acks + int'(irq_ack));
  end

  task automatic step(input int kind, input ras_pc_t pc);
    @(posedge clk);
    core_req <= {kind == 0, kind == 1, kind == 2, pc};
    @(posedge clk);
    core_req <= {3'b000, pc};
  endtask : step

  // raised off the edge so the request process sees it cleanly
  task automatic raise_irq();
    @(negedge clk);
    asked = asked + 1;
  endtask : raise_irq
endmodule : ras_core_model

`default_nettype wire

// >>> sim/test_return_address_stack.sv
// self-checking bench for the return address stack
`timescale 1ns/1ps
`default_nettype none

module test_return_address_stack
  import ras_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hresp;
  ras_core_req_t core_req;
  logic irq_req;
  logic irq_ack;
  ras_pc_t pc_out;
  logic pc_out_valid;
  logic [31:0] rd;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  ras_top u_dut (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .CORE_REQ(core_req), .IRQ_REQ(irq_req),
    .IRQ_ACK(irq_ack), .PC_OUT(pc_out), .PC_OUT_VALID(pc_out_valid));

  ras_core_model u_core (.clk(clk), .irq_ack(irq_ack), .core_req(core_req),
    .irq_req(irq_req));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    check("resp", {31'h0, hresp}, 32'h0);
    check("ready", {31'h0, hready}, 32'h1);
  endtask : bus

  task automatic expect_stat(input logic [31:0] exp);
    bus(1'b0, 32'h0, 32'h0);
    check("status", rd, exp);
  endtask : expect_stat

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    expect_stat(32'h00);
    bus(1'b1, 32'h0, 32'hFF);
    expect_stat(32'h80);
    bus(1'b1, 32'h0, 32'h00);
    expect_stat(32'h00);
    bus(1'b0, 32'h4, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      u_core.step(0, 15'(32'h100 + i));
      expect_stat(32'((i + 1) % 16));
    end
    // full stack: interrupt must wait for a return
    u_core.raise_irq();
    repeat (6) @(posedge clk);
    check("ack_held", 32'(u_core.acks), 32'h0);
    u_core.step(1, 15'h7AB);
    #1;
    check("pc_out", {17'h0, pc_out}, 32'h10F);
    check("pc_valid", {31'h0, pc_out_valid}, 32'h1);
    repeat (4) @(posedge clk);
    check("ack_done", 32'(u_core.acks), 32'h1);
    expect_stat(32'h00);
    u_core.step(0, 15'h222);
    expect_stat(32'h81);
    u_core.step(1, 15'h0);
    #1;
    check("pc_over", {17'h0, pc_out}, 32'h222);
    @(posedge clk);
    #1;
    check("pc_drop", {31'h0, pc_out_valid}, 32'h0);
    u_core.step(2, 15'h0);
    #1;
    check("pc_irq", {17'h0, pc_out}, 32'h7AB);
    expect_stat(32'h8F);
    bus(1'b1, 32'h0, 32'h0F);
    expect_stat(32'h0F);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    expect_stat(32'h00);
    // underflow, alternating both return kinds
    for (int i = 0; i < 16; i++)
    begin
      u_core.step(1 + i % 2, 15'h0);
      expect_stat(32'h80 | 32'((15 - i) % 16));
    end
    stop_test();
  end
endmodule : test_return_address_stack

`default_nettype wire
